// ===== uefc_defs.vh
// Offsets, field positions, reset values and timing counts for the feature block.
`ifndef UEFC_DEFS_VH
`define UEFC_DEFS_VH
`define UEFC_OFS_EXT_CTRL 8'h00
`define UEFC_OFS_SCRATCH 8'h04
`define UEFC_OFS_FEAT_CTRL 8'h08
`define UEFC_OFS_ENH_FEAT 8'h0c
`define UEFC_OFS_OFF_ONE 8'h10
`define UEFC_OFS_OFF_TWO 8'h14
`define UEFC_OFS_ON_ONE 8'h18
`define UEFC_OFS_ON_TWO 8'h1c
`define UEFC_OFS_MODEM_CTRL 8'h20
`define UEFC_OFS_INT_STAT 8'h24
`define UEFC_OFS_LINE_STATE 8'h28
`define UEFC_RST_SCRATCH 8'hff
`define UEFC_RST_ZERO 8'h00
`define UEFC_EXT_NINE 0
`define UEFC_EXT_RX_HALT 2
`define UEFC_EXT_TX_HALT 3
`define UEFC_FC_IR_INV 4
`define UEFC_FC_RS485 5
`define UEFC_EF_ENH 4
`define UEFC_EF_SPECIAL 5
`define UEFC_EF_AUTO_OUT 6
`define UEFC_EF_AUTO_IN 7
`define UEFC_MC_DTR 0
`define UEFC_MC_RTS 1
`define UEFC_MC_SEL 2
`define UEFC_IS_XOFF 0
`define UEFC_IS_XON 1
`define UEFC_IS_SPECIAL 4
`define UEFC_EXT_PROT_MASK 8'hfc
`define UEFC_MC_PROT_MASK 8'hec
`define UEFC_TICKS_PER_BIT 5'h10
`define UEFC_MID_TICK 4'h7
`define UEFC_LAST_TICK 4'hf
`endif

// ===== uefc_partner.sv
// Serial line partner that frames characters to and from the block.
`timescale 1ns/1ps
module uefc_partner #(
  parameter BIT = 32
) (
  input wire clk,
  input wire tx,
  output logic rx
);
  logic [7:0] got [$];
  logic [7:0] sh;
  initial rx = 1'b1;
  // Decodes each frame on the transmit line at mid-bit.
  always
  begin
    @(negedge tx);
    repeat (BIT / 2) @(posedge clk);
    for (int k = 0; k < 8; k++)
    begin
      repeat (BIT) @(posedge clk);
      sh[k] = tx;
    end
    repeat (BIT) @(posedge clk);
    got.push_back(sh);
  end
  // Sends one frame and leaves the line high afterwards.
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    begin
      f = {1'b1, d, 1'b0};
      for (int k = 0; k < 10; k++)
      begin
        rx <= f[k];
        repeat (BIT) @(posedge clk);
      end
    end
  endtask
endmodule

// ===== uefc_properties.sv
// Port-level checker for the enhanced feature block and its bind.
`timescale 1ns/1ps
`include "uefc_defs.vh"
module uefc_properties (
  // Clock and reset
  input wire I_CORE_CLK,
  input wire I_RESETN,
  // Wishbone slave
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [7:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  input wire [31:0] O_WB_DAT,
  input wire O_WB_ACK,
  // Transmit side
  input wire I_TXF_VALID,
  input wire O_TXF_POP,
  input wire O_TX,
  input wire O_RTS_N,
  input wire O_TX_INT
);
  wire wr_ok = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && I_WB_SEL[0];
  reg enh_r;
  reg halt_r;
  reg m485_r;
  reg [5:0] low_r;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  // Tracks the mode bits from bus writes and the length of low runs on the line.
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      enh_r <= 1'b0;
      halt_r <= 1'b0;
      m485_r <= 1'b0;
      low_r <= 6'h00;
    end
    else
    begin
      if (wr_ok && I_WB_ADR == `UEFC_OFS_ENH_FEAT)
        enh_r <= I_WB_DAT[4];
      if (wr_ok && enh_r && I_WB_ADR == `UEFC_OFS_EXT_CTRL)
        halt_r <= I_WB_DAT[3];
      if (wr_ok && I_WB_ADR == `UEFC_OFS_FEAT_CTRL)
        m485_r <= I_WB_DAT[5];
      low_r <= O_TX ? 6'h00 : (low_r == 6'h3f ? low_r : low_r + 6'h01);
    end
  end
  sequence s_start_soon;
    ##[1:2] (!O_TX && O_RTS_N);
  endsequence
  a_ack_one_wait: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack not given one cycle after request");
  a_ack_one_cycle: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_ack_on_request: assert property (O_WB_ACK |-> $past(I_WB_STB))
    else $error("ack without request");
  a_read_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_pop_needs_data: assert property (O_TXF_POP |-> I_TXF_VALID)
    else $error("pop from empty transmit queue");
  a_halt_blocks_pop: assert property (halt_r |-> !O_TXF_POP)
    else $error("character taken while transmitter halted");
  a_launch_start_bit: assert property (!m485_r && O_TXF_POP |=> !O_TX)
    else $error("start bit not one cycle after pop");
  a_rs485_lead: assert property (m485_r && O_TXF_POP |-> s_start_soon)
    else $error("start bit without direction output high");
  a_rs485_hold: assert property (m485_r && !O_TX |-> O_RTS_N && !O_TX_INT)
    else $error("direction or interrupt wrong while shifting");
  a_bit_length: assert property ($rose(O_TX) |-> low_r >= 6'h1e)
    else $error("low bit shorter than one bit time");
endmodule
bind uefc_top uefc_properties uefc_properties_i (
  .I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_TXF_VALID(I_TXF_VALID), .O_TXF_POP(O_TXF_POP),
  .O_TX(O_TX), .O_RTS_N(O_RTS_N), .O_TX_INT(O_TX_INT)
);

// ===== uefc_rx.v
// Serial character receiver with optional ninth data bit.
`timescale 1ns/1ps
module uefc_rx (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Timing and control
  input wire tick16,
  input wire allow,
  input wire nine,
  // Line side
  input wire line,
  // Character out
  output wire busy,
  output wire started,
  output reg valid,
  output reg [8:0] data
);
`include "uefc_defs.vh"
  reg busy_r;
  reg [3:0] tcnt_r;
  reg [3:0] bcnt_r;
  reg [8:0] sh_r;
  wire [3:0] stop_bit;

  assign stop_bit = nine ? 4'ha : 4'h9;
  assign busy = busy_r;
  assign started = !busy_r && allow && !line;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      tcnt_r <= 4'h0;
      bcnt_r <= 4'h0;
      sh_r <= 9'h000;
      valid <= 1'b0;
      data <= 9'h000;
    end
    else
    begin
      valid <= 1'b0;
      if (started)
      begin
        busy_r <= 1'b1;
        tcnt_r <= 4'h0;
        bcnt_r <= 4'h0;
      end
      else if (busy_r && tick16)
      begin
        tcnt_r <= tcnt_r + 4'h1;
        if (tcnt_r == `UEFC_MID_TICK)
        begin
          bcnt_r <= bcnt_r + 4'h1;
          if (bcnt_r == 4'h0 && line)
            busy_r <= 1'b0;
          else if (bcnt_r == stop_bit)
          begin
            busy_r <= 1'b0;
            valid <= 1'b1;
            data <= nine ? sh_r : {1'b0, sh_r[8:1]};
          end
          else if (bcnt_r != 4'h0)
            sh_r <= {line, sh_r[8:1]};
        end
      end
    end
  end
endmodule

// ===== uefc_top.v
// Enhanced feature control of one UART channel with a Wishbone register port.
// Operation
// - Transmit halt stops characters, FIFO keeps bytes.
// - Clearing transmit halt resumes sending FIFO bytes.
// - Receive halt mid-character finishes that character.
// - Receive halt while idle takes one more character.
// - Receive FIFO stays readable while reception halted.
// - Extended control bit 0 selects nine-bit mode.
// - Scratch pad resets to all ones.
// - RS-485 mode moves transmit interrupt to shifter empty.
// - RS-485 drops RTS after last stop bit.
// - RS-485 raises RTS before the start bit.
// - Infrared polarity bit inverts receive data.
// - Auto input flow control stops on CTS/DSR high.
// - Auto output flow drives RTS/DTR by FIFO triggers.
// - Special character match sets status bit 4.
// - Second-pair compare drops special Xoff, both events.
// - Enhanced bits writable only with enhanced-enable set.
// - Transmit bits 3:2 pick sent control characters.
// - Receive bits 1:0 pick compared control characters.
// - Dual transmit mode sends two characters in sequence.
// - Turnaround delay of 0 to 15 bit times.
// - Flow stop waits for current character end.
`timescale 1ns/1ps
module uefc_top (
  // Clock and reset
  input wire I_CORE_CLK,
  input wire I_RESETN,
  // Wishbone slave
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [7:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output wire O_WB_ACK,
  // Sixteen-times bit rate enable
  input wire I_TICK16,
  // Transmit FIFO read side
  input wire I_TXF_VALID,
  input wire [8:0] I_TXF_DATA,
  output wire O_TXF_POP,
  // Receive FIFO write side and trigger flags
  output reg O_RXF_PUSH,
  output reg [8:0] O_RXF_DATA,
  input wire I_RXF_AT_TRIG,
  input wire I_RXF_ABOVE_UPPER,
  input wire I_RXF_BELOW_LOWER,
  // Serial and modem pins
  input wire I_RX,
  input wire I_CTS_N,
  input wire I_DSR_N,
  output wire O_TX,
  output wire O_RTS_N,
  output wire O_DTR_N,
  // Event outputs
  output wire O_TX_INT,
  output wire O_RX_TRIG_INT
);
`include "uefc_defs.vh"
  reg ack_r;
  reg [7:0] ext_ctrl_r;
  reg [7:0] scratch_r;
  reg [7:0] feat_ctrl_r;
  reg [7:0] enh_feat_r;
  reg [7:0] off_one_r;
  reg [7:0] off_two_r;
  reg [7:0] on_one_r;
  reg [7:0] on_two_r;
  reg [7:0] modem_ctrl_r;
  reg [7:0] int_stat_r;
  reg [7:0] int_stat_nxt;
  reg [31:0] rd_nxt;
  reg [2:0] rx_sync_r;
  reg [1:0] cts_sync_r;
  reg [1:0] dsr_sync_r;
  reg rx_halt_q_r;
  reg one_more_r;
  reg launch_r;
  reg [1:0] ctl_left_r;
  reg ctl_is_off_r;
  reg sent_off_r;
  reg remote_off_r;
  reg off_one_seen_r;
  reg on_one_seen_r;
  reg flow_hold_r;
  reg rts485_r;
  reg [3:0] turn_tick_r;
  reg [4:0] turn_bits_r;
  wire wr_en;
  wire [7:0] wd;
  wire tx_halt;
  wire rx_halt;
  wire nine;
  wire rx_line;
  wire flow_in;
  wire in_stop;
  wire tx_busy;
  wire tx_done;
  wire rx_busy;
  wire rx_started;
  wire rx_valid;
  wire [8:0] rx_data;
  wire [1:0] txm;
  wire [1:0] rxm;
  wire tx_gate;
  wire send_ctl;
  wire send_data;
  wire [7:0] ctl_char;
  wire [8:0] tx_word;
  wire tx_idle;
  wire single1;
  wire single2;
  wire dual;
  wire [7:0] rc;
  wire m_off;
  wire m_on;
  wire special;

  // Register port.
  assign O_WB_ACK = ack_r;
  assign wr_en = I_WB_CYC && I_WB_STB && I_WB_WE && ack_r && I_WB_SEL[0];
  assign wd = I_WB_DAT[7:0];
  assign tx_halt = ext_ctrl_r[`UEFC_EXT_TX_HALT];
  assign rx_halt = ext_ctrl_r[`UEFC_EXT_RX_HALT];
  assign nine = ext_ctrl_r[`UEFC_EXT_NINE];
  assign txm = enh_feat_r[3:2];
  assign rxm = enh_feat_r[1:0];

  always @*
  begin
    rd_nxt = 32'h00000000;
    case (I_WB_ADR)
      `UEFC_OFS_SCRATCH: rd_nxt[7:0] = scratch_r;
      `UEFC_OFS_FEAT_CTRL: rd_nxt[7:0] = feat_ctrl_r;
      `UEFC_OFS_ENH_FEAT: rd_nxt[7:0] = enh_feat_r;
      `UEFC_OFS_MODEM_CTRL: rd_nxt[7:0] = modem_ctrl_r;
      `UEFC_OFS_INT_STAT: rd_nxt[7:0] = int_stat_r;
      `UEFC_OFS_LINE_STATE: rd_nxt[7:0] = {2'h0, flow_hold_r, in_stop, remote_off_r,
                                           rts485_r, rx_busy, tx_busy};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      ack_r <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end
    else
    begin
      ack_r <= I_WB_CYC && I_WB_STB && !ack_r;
      if (I_WB_CYC && I_WB_STB && !ack_r)
        O_WB_DAT <= rd_nxt;
    end
  end

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      ext_ctrl_r <= `UEFC_RST_ZERO;
      scratch_r <= `UEFC_RST_SCRATCH;
      feat_ctrl_r <= `UEFC_RST_ZERO;
      enh_feat_r <= `UEFC_RST_ZERO;
      off_one_r <= `UEFC_RST_ZERO;
      off_two_r <= `UEFC_RST_ZERO;
      on_one_r <= `UEFC_RST_ZERO;
      on_two_r <= `UEFC_RST_ZERO;
      modem_ctrl_r <= `UEFC_RST_ZERO;
    end
    else if (wr_en)
    begin
      case (I_WB_ADR)
        `UEFC_OFS_EXT_CTRL:
          if (enh_feat_r[`UEFC_EF_ENH])
            ext_ctrl_r <= wd & 8'hfd;
          else
            ext_ctrl_r <= (ext_ctrl_r & `UEFC_EXT_PROT_MASK) |
                          (wd & 8'h01);
        `UEFC_OFS_SCRATCH: scratch_r <= wd;
        `UEFC_OFS_FEAT_CTRL: feat_ctrl_r <= wd & 8'h30;
        `UEFC_OFS_ENH_FEAT: enh_feat_r <= wd;
        `UEFC_OFS_OFF_ONE: off_one_r <= wd;
        `UEFC_OFS_OFF_TWO: off_two_r <= wd;
        `UEFC_OFS_ON_ONE: on_one_r <= wd;
        `UEFC_OFS_ON_TWO: on_two_r <= wd;
        `UEFC_OFS_MODEM_CTRL:
          if (enh_feat_r[`UEFC_EF_ENH])
            modem_ctrl_r <= wd;
          else
            modem_ctrl_r <= (modem_ctrl_r & `UEFC_MC_PROT_MASK) |
                            (wd & ~`UEFC_MC_PROT_MASK);
        default: scratch_r <= scratch_r;
      endcase
    end
  end

  // Pin synchronisers; the receive line is inverted for infrared polarity.
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      rx_sync_r <= 3'h7;
      cts_sync_r <= 2'h3;
      dsr_sync_r <= 2'h3;
    end
    else
    begin
      rx_sync_r <= {rx_sync_r[1:0], I_RX};
      cts_sync_r <= {cts_sync_r[0], I_CTS_N};
      dsr_sync_r <= {dsr_sync_r[0], I_DSR_N};
    end
  end

  assign rx_line = rx_sync_r[1] ^ feat_ctrl_r[`UEFC_FC_IR_INV];
  assign flow_in = modem_ctrl_r[`UEFC_MC_SEL] ? dsr_sync_r[1] : cts_sync_r[1];
  assign in_stop = enh_feat_r[`UEFC_EF_AUTO_IN] && flow_in;

  // Transmit launch: control characters first, then FIFO data.
  assign tx_gate = !tx_busy && !launch_r && !tx_halt && !in_stop &&
                   (!feat_ctrl_r[`UEFC_FC_RS485] || rts485_r);
  assign send_ctl = tx_gate && (ctl_left_r != 2'h0);
  assign send_data = tx_gate && !send_ctl && I_TXF_VALID && !remote_off_r;
  assign O_TXF_POP = send_data;
  assign ctl_char = (ctl_left_r == 2'h2 || txm == 2'h2) ?
                    (ctl_is_off_r ? off_one_r : on_one_r) :
                    (ctl_is_off_r ? off_two_r : on_two_r);
  assign tx_word = send_ctl ? {1'b0, ctl_char} : I_TXF_DATA;

  uefc_tx u_tx (
    .clk(I_CORE_CLK),
    .rst_n(I_RESETN),
    .tick16(I_TICK16),
    .start(send_ctl || send_data),
    .nine(nine),
    .data(tx_word),
    .line(O_TX),
    .busy(tx_busy),
    .done(tx_done)
  );

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      launch_r <= 1'b0;
      ctl_left_r <= 2'h0;
      ctl_is_off_r <= 1'b0;
      sent_off_r <= 1'b0;
    end
    else
    begin
      launch_r <= send_ctl || send_data;
      if (txm == 2'h0)
      begin
        ctl_left_r <= 2'h0;
        sent_off_r <= 1'b0;
      end
      else if (send_ctl)
        ctl_left_r <= ctl_left_r - 2'h1;
      else if (ctl_left_r == 2'h0 && I_RXF_ABOVE_UPPER && !sent_off_r)
      begin
        ctl_left_r <= (txm == 2'h3) ? 2'h2 : 2'h1;
        ctl_is_off_r <= 1'b1;
        sent_off_r <= 1'b1;
      end
      else if (ctl_left_r == 2'h0 && I_RXF_BELOW_LOWER && sent_off_r)
      begin
        ctl_left_r <= (txm == 2'h3) ? 2'h2 : 2'h1;
        ctl_is_off_r <= 1'b0;
        sent_off_r <= 1'b0;
      end
    end
  end

  // RS-485 direction with turnaround delay counted in bit times.
  assign tx_idle = !tx_busy && !launch_r && !I_TXF_VALID && ctl_left_r == 2'h0;

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      rts485_r <= 1'b0;
      turn_tick_r <= 4'h0;
      turn_bits_r <= 5'h00;
    end
    else if (!tx_idle)
    begin
      rts485_r <= 1'b1;
      turn_tick_r <= 4'h0;
      turn_bits_r <= 5'h00;
    end
    else if (turn_bits_r >= {1'b0, ext_ctrl_r[7:4]})
      rts485_r <= 1'b0;
    else if (I_TICK16)
    begin
      turn_tick_r <= turn_tick_r + 4'h1;
      if (turn_tick_r == `UEFC_LAST_TICK)
        turn_bits_r <= turn_bits_r + 5'h01;
    end
  end

  assign O_TX_INT = feat_ctrl_r[`UEFC_FC_RS485] ?
                    (!I_TXF_VALID && !tx_busy && !launch_r) : !I_TXF_VALID;

  // Auto output flow control on the selected modem pin.
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
      flow_hold_r <= 1'b0;
    else if (!enh_feat_r[`UEFC_EF_AUTO_OUT])
      flow_hold_r <= 1'b0;
    else if (I_RXF_ABOVE_UPPER)
      flow_hold_r <= 1'b1;
    else if (I_RXF_BELOW_LOWER)
      flow_hold_r <= 1'b0;
  end

  assign O_RX_TRIG_INT = enh_feat_r[`UEFC_EF_AUTO_OUT] && I_RXF_AT_TRIG;
  assign O_RTS_N = feat_ctrl_r[`UEFC_FC_RS485] ? rts485_r :
                   (!modem_ctrl_r[`UEFC_MC_RTS] ||
                    (flow_hold_r && !modem_ctrl_r[`UEFC_MC_SEL]));
  assign O_DTR_N = !modem_ctrl_r[`UEFC_MC_DTR] ||
                   (flow_hold_r && modem_ctrl_r[`UEFC_MC_SEL]);

  // Receive halt lets the current or exactly one further character in.
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      rx_halt_q_r <= 1'b0;
      one_more_r <= 1'b0;
    end
    else
    begin
      rx_halt_q_r <= rx_halt;
      if (rx_halt && !rx_halt_q_r)
        one_more_r <= !rx_busy;
      else if (rx_started)
        one_more_r <= 1'b0;
    end
  end

  uefc_rx u_rx (
    .clk(I_CORE_CLK),
    .rst_n(I_RESETN),
    .tick16(I_TICK16),
    .allow(!rx_halt || one_more_r),
    .nine(nine),
    .line(rx_line),
    .busy(rx_busy),
    .started(rx_started),
    .valid(rx_valid),
    .data(rx_data)
  );

  // Received control character comparison.
  assign rc = rx_data[7:0];
  assign single1 = rxm == 2'h2 || (rxm == 2'h3 && (txm == 2'h2 || txm == 2'h1));
  assign single2 = rxm == 2'h1 || (rxm == 2'h3 && (txm == 2'h2 || txm == 2'h1));
  assign dual = rxm == 2'h3 && (txm == 2'h3 || txm == 2'h0);
  assign m_off = (single1 && rc == off_one_r) || (single2 && rc == off_two_r) ||
                 (dual && off_one_seen_r && rc == off_two_r);
  assign m_on = !m_off && ((single1 && rc == on_one_r) || (single2 && rc == on_two_r) ||
                (dual && on_one_seen_r && rc == on_two_r));
  assign special = enh_feat_r[`UEFC_EF_SPECIAL] && rc == off_two_r;

  always @*
  begin
    int_stat_nxt = int_stat_r;
    if (wr_en && I_WB_ADR == `UEFC_OFS_INT_STAT)
      int_stat_nxt = int_stat_r & ~wd;
    if (rx_valid && m_off)
      int_stat_nxt[`UEFC_IS_XOFF] = 1'b1;
    if (rx_valid && m_on)
      int_stat_nxt[`UEFC_IS_XON] = 1'b1;
    if (rx_valid && special)
      int_stat_nxt[`UEFC_IS_SPECIAL] = 1'b1;
  end

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      int_stat_r <= `UEFC_RST_ZERO;
      remote_off_r <= 1'b0;
      off_one_seen_r <= 1'b0;
      on_one_seen_r <= 1'b0;
      O_RXF_PUSH <= 1'b0;
      O_RXF_DATA <= 9'h000;
    end
    else
    begin
      int_stat_r <= int_stat_nxt;
      O_RXF_PUSH <= rx_valid && !m_off && !m_on;
      if (rx_valid)
      begin
        O_RXF_DATA <= rx_data;
        off_one_seen_r <= rc == off_one_r;
        on_one_seen_r <= rc == on_one_r;
      end
      if (rxm == 2'h0)
        remote_off_r <= 1'b0;
      else if (rx_valid && m_off)
        remote_off_r <= 1'b1;
      else if (rx_valid && m_on)
        remote_off_r <= 1'b0;
    end
  end
endmodule

// ===== uefc_top_bench.sv
// Self-checking bench for the enhanced feature block.
`timescale 1ns/1ps
`include "uefc_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uefc_top_bench;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
  logic txv = 1'b0, trig = 1'b0, upper = 1'b0, lower = 1'b0, cts_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [8:0] txd = 9'h000;
  wire [31:0] rdat;
  wire [8:0] rxd;
  wire ack, pop, push, tx, rx, rts_n, dtr_n, tx_int, trig_int;
  logic [8:0] pushed [$];
  logic [7:0] q, b, c;
  logic [7:0] ch [4];
  int miscompares = 0, comparisons = 0, seed = 32'h1726fac9, n;
  uefc_top uefc_top_i (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_TICK16(tick), .I_TXF_VALID(txv), .I_TXF_DATA(txd), .O_TXF_POP(pop),
    .O_RXF_PUSH(push), .O_RXF_DATA(rxd), .I_RXF_AT_TRIG(trig), .I_RXF_ABOVE_UPPER(upper),
    .I_RXF_BELOW_LOWER(lower), .I_RX(rx), .I_CTS_N(cts_n), .I_DSR_N(1'b0), .O_TX(tx),
    .O_RTS_N(rts_n), .O_DTR_N(dtr_n), .O_TX_INT(tx_int), .O_RX_TRIG_INT(trig_int));
  uefc_partner uefc_partner_i (.clk(clk), .tx(tx), .rx(rx));
  always #12.5 clk = ~clk;
  always @(posedge clk) tick <= ~tick;
  always @(posedge clk) if (push === 1'b1) pushed.push_back(rxd);
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    begin
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      @(posedge clk);
      while (ack !== 1'b1 && k < 20)
      begin
        @(posedge clk);
        k++;
      end
      if (k >= 20) miscompares++;
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic launch(input logic [7:0] d);
    int k;
    begin
      k = 0;
      txv <= 1'b1;
      txd <= {1'b0, d};
      @(posedge clk);
      while (pop !== 1'b1 && k < 2000)
      begin
        @(posedge clk);
        k++;
      end
      `CHK(pop, 1'b1)
      txv <= 1'b0;
    end
  endtask
  task automatic blocked(input logic [7:0] d);
    begin
      n = 0;
      txv <= 1'b1;
      txd <= {1'b0, d};
      repeat (400)
      begin
        @(posedge clk);
        if (pop !== 1'b0) n++;
      end
      `CHK(n, 0)
      txv <= 1'b0;
    end
  endtask
  task automatic expect_tx(input logic [7:0] d);
    begin
      n = 0;
      while (uefc_partner_i.got.size() == 0 && n < 900)
      begin
        @(posedge clk);
        n++;
      end
      `CHK(uefc_partner_i.got.size() > 0, 1'b1)
      if (uefc_partner_i.got.size() > 0) `CHK(uefc_partner_i.got.pop_front(), d)
    end
  endtask
  task automatic rx_got(input logic [7:0] d, input int cnt);
    begin
      repeat (40) @(posedge clk);
      `CHK(pushed.size(), cnt)
      if (cnt > 0 && pushed.size() > 0) `CHK(pushed.pop_front(), {1'b0, d})
    end
  endtask
  task automatic rx_chk(input logic [7:0] d, input int cnt);
    begin
      uefc_partner_i.send(d);
      rx_got(d, cnt);
    end
  endtask
  task automatic final_report;
    begin
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wb(0, `UEFC_OFS_SCRATCH, 8'h00);
    `CHK(q, `UEFC_RST_SCRATCH)
    wb(1, 8'h3c, 8'h5a);
    wb(0, 8'h3c, 8'h00);
    `CHK(q, 8'h00)
    b = 8'($random(seed));
    c = 8'($random(seed));
    wb(1, `UEFC_OFS_SCRATCH, b);
    wb(0, `UEFC_OFS_SCRATCH, 8'h00);
    `CHK(q, b)
    wb(1, `UEFC_OFS_MODEM_CTRL, 8'h04);
    wb(0, `UEFC_OFS_MODEM_CTRL, 8'h00);
    `CHK(q, 8'h00)
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h10);
    wb(1, `UEFC_OFS_MODEM_CTRL, 8'h04);
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h00);
    wb(1, `UEFC_OFS_MODEM_CTRL, 8'h00);
    wb(0, `UEFC_OFS_MODEM_CTRL, 8'h00);
    `CHK(q, 8'h04)
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h10);
    wb(1, `UEFC_OFS_MODEM_CTRL, 8'h00);
    launch(b);
    expect_tx(b);
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h08);
    blocked(c);
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h00);
    launch(c);
    expect_tx(c);
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h90);
    launch(b);
    cts_n <= 1'b1;
    expect_tx(b);
    blocked(c);
    cts_n <= 1'b0;
    launch(c);
    expect_tx(c);
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h10);
    wb(1, `UEFC_OFS_FEAT_CTRL, 8'h20);
    for (int d = 0; d < 16; d += 15)
    begin
      wb(1, `UEFC_OFS_EXT_CTRL, 8'(d << 4));
      launch(b);
      repeat (4) @(posedge clk);
      `CHK({rts_n, tx_int}, 2'b10)
      n = 0;
      while (tx_int !== 1'b1 && n < 900)
      begin
        @(posedge clk);
        n++;
      end
      n = 0;
      while (rts_n !== 1'b0 && n < 900)
      begin
        @(posedge clk);
        n++;
      end
      `CHK(n + 2 >= d * 32 && n <= d * 32 + 3, 1'b1)
      expect_tx(b);
    end
    wb(1, `UEFC_OFS_FEAT_CTRL, 8'h00);
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h00);
    launch(c);
    repeat (4) @(posedge clk);
    `CHK(tx_int, 1'b1)
    expect_tx(c);
    fork
      uefc_partner_i.send(b);
      begin
        repeat (100) @(posedge clk);
        wb(1, `UEFC_OFS_EXT_CTRL, 8'h04);
      end
    join
    rx_got(b, 1);
    rx_chk(c, 0);
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h00);
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h04);
    rx_chk(c, 1);
    rx_chk(b, 0);
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h00);
    rx_chk(b, 1);
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h01);
    uefc_partner_i.send(c);
    repeat (80) @(posedge clk);
    `CHK(pushed.size(), 1)
    if (pushed.size() > 0) `CHK(pushed.pop_front(), {1'b1, c})
    wb(1, `UEFC_OFS_EXT_CTRL, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      ch[i] = 8'($random(seed));
      wb(1, 8'(`UEFC_OFS_OFF_ONE + 4 * i), ch[i]);
    end
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h30);
    rx_chk(ch[1], 1);
    wb(0, `UEFC_OFS_INT_STAT, 8'h00);
    `CHK(q & 8'h10, 8'h10)
    wb(1, `UEFC_OFS_INT_STAT, 8'hff);
    for (int m = 1; m < 4; m++)
    begin
      wb(1, `UEFC_OFS_ENH_FEAT, 8'h10);
      wb(1, `UEFC_OFS_ENH_FEAT, 8'(8'h10 | (m << 2)));
      upper <= 1'b1;
      if (m[1]) expect_tx(ch[0]);
      if (m[0]) expect_tx(ch[1]);
      upper <= 1'b0;
      lower <= 1'b1;
      if (m[1]) expect_tx(ch[2]);
      if (m[0]) expect_tx(ch[3]);
      lower <= 1'b0;
    end
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h10);
    wb(1, `UEFC_OFS_MODEM_CTRL, 8'h02);
    `CHK({rts_n, dtr_n}, 2'b01)
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h50);
    trig <= 1'b1;
    upper <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({trig_int, rts_n}, 2'b11)
    trig <= 1'b0;
    upper <= 1'b0;
    lower <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(rts_n, 1'b0)
    lower <= 1'b0;
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h10);
    wb(1, `UEFC_OFS_ENH_FEAT, 8'h31);
    rx_chk(ch[1], 0);
    wb(0, `UEFC_OFS_INT_STAT, 8'h00);
    `CHK(q & 8'h11, 8'h11)
    final_report;
  end
endmodule

// ===== uefc_tx.v
// Serial character transmitter with optional ninth data bit.
`timescale 1ns/1ps
module uefc_tx (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Timing and control
  input wire tick16,
  input wire start,
  input wire nine,
  input wire [8:0] data,
  // Line side
  output wire line,
  output wire busy,
  output reg done
);
`include "uefc_defs.vh"
  reg busy_r;
  reg [10:0] sh_r;
  reg [3:0] tcnt_r;
  reg [3:0] bcnt_r;
  wire [3:0] last_bit;

  assign last_bit = nine ? 4'ha : 4'h9;
  assign busy = busy_r;
  assign line = busy_r ? sh_r[0] : 1'b1;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      sh_r <= 11'h7ff;
      tcnt_r <= 4'h0;
      bcnt_r <= 4'h0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy_r && start)
      begin
        busy_r <= 1'b1;
        sh_r <= nine ? {1'b1, data, 1'b0} : {2'h3, data[7:0], 1'b0};
        tcnt_r <= 4'h0;
        bcnt_r <= 4'h0;
      end
      else if (busy_r && tick16)
      begin
        tcnt_r <= tcnt_r + 4'h1;
        if (tcnt_r == `UEFC_LAST_TICK)
        begin
          sh_r <= {1'b1, sh_r[10:1]};
          bcnt_r <= bcnt_r + 4'h1;
          if (bcnt_r == last_bit)
          begin
            busy_r <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule
